/* core/dfbc_bufmgr.sv */
`timescale 1ns/1ns
`default_nettype none
module dfbc_bufmgr #(
  parameter bit TRIPLE = 1'b0,
  parameter bit MOTION = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       in_done,
  input  wire logic       in_keep,
  input  wire logic       out_done,
  input  wire logic       out_take,
  output logic [1:0]      wr_id,
  output logic [1:0]      rd_id,
  output logic [1:0]      pv_id,
  output logic            spare_clean,
  output logic            in_wait,
  output logic            dropped,
  output logic            repeated
);
  logic [1:0] wr_q, rd_q, pv_q, sp_q, wr_d, rd_d, pv_d, sp_d;
  logic       cl_q, cl_d, ip_q, ip_d, op_q, op_d, dr_q, dr_d, rp_q, rp_d;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    pv_d = pv_q;
    sp_d = sp_q;
    cl_d = cl_q;
    ip_d = ip_q;
    op_d = op_q;
    dr_d = 1'b0;
    rp_d = 1'b0;
    if (TRIPLE) begin
      // The output side is served first, so a same-cycle input sees its result.
      if (out_done) begin
        if (cl_q) begin
          rd_d = sp_q;
          sp_d = MOTION ? pv_q : rd_q;
          pv_d = MOTION ? rd_q : pv_q;
          cl_d = 1'b0;
        end else begin
          rp_d = 1'b1;
        end
      end
      if (in_done) begin
        if (!cl_d && in_keep) begin
          wr_d = sp_d;
          sp_d = wr_q;
          cl_d = 1'b1;
        end else begin
          dr_d = 1'b1;
        end
      end
    end else begin
      if (in_done && in_keep) ip_d = 1'b1;
      if (in_done && !in_keep) dr_d = 1'b1;
      if (out_done && out_take) op_d = 1'b1;
      if (out_done && !out_take) rp_d = 1'b1;
      if (ip_d && op_d) begin
        ip_d = 1'b0;
        op_d = 1'b0;
        rd_d = wr_q;
        wr_d = MOTION ? pv_q : rd_q;
        pv_d = MOTION ? rd_q : pv_q;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= dfbc_pkg::WR_ID_RST;
      rd_q <= dfbc_pkg::RD_ID_RST;
      pv_q <= dfbc_pkg::PV_ID_RST;
      sp_q <= MOTION ? dfbc_pkg::SP_ID_RST_MA : dfbc_pkg::SP_ID_RST;
      cl_q <= 1'b0;
      ip_q <= 1'b0;
      op_q <= 1'b0;
      dr_q <= 1'b0;
      rp_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      pv_q <= pv_d;
      sp_q <= sp_d;
      cl_q <= cl_d;
      ip_q <= ip_d;
      op_q <= op_d;
      dr_q <= dr_d;
      rp_q <= rp_d;
    end
  end

  assign wr_id       = wr_q;
  assign rd_id       = rd_q;
  assign pv_id       = pv_q;
  assign spare_clean = cl_q;
  assign in_wait     = ip_q;
  assign dropped     = dr_q;
  assign repeated    = rp_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_areas_apart: assert property (wr_q != rd_q)
    else $error("input and output own the same area");
  a_spare_drop: assert property (TRIPLE && in_done && cl_q && !out_done |=>
    $stable(wr_q) && dr_q) else $error("clean spare was overwritten");
  a_spare_repeat: assert property (TRIPLE && out_done && !cl_q |=>
    $stable(rd_q) && rp_q) else $error("output swapped with a stale spare");
  a_pair_swap: assert property (!TRIPLE && $changed(rd_q) |->
    $past(ip_d && op_d || ip_q && op_q || (in_done || ip_q) && (out_done || op_q)))
    else $error("double buffer swapped before both sides finished");
  a_motion_keep: assert property (MOTION && $changed(rd_q) |->
    pv_q == $past(rd_q)) else $error("frame n-1 not kept");
endmodule
`default_nettype wire

/* core/dfbc_top.sv */
// Functional notes
// - Bob allows none, double or triple buffering; weave and motion need buffering.
// - Double buffering keeps one write area and one read area.
// - Double buffering swaps areas only once both sides finish a frame.
// - Motion double buffering uses three areas, replacing oldest frame and keeping n-1.
// - Triple buffering uses three areas, four for motion, one kept spare.
// - Finished input swaps with a consumed spare, otherwise its frame is dropped.
// - Finished output swaps with a fresh spare, otherwise repeats its frame.
// - Buffered builds expose separate write and read memory addresses.
// - Memory addresses are stable per frame so masters may use another clock.
// - With alignment, areas start on multiples of the larger burst target.
// - Locked rate mode drops or repeats frames deterministically from set rates.
// - Locked rate works with passthrough, never with motion override.
// - Field type comes from control packets, else follows the previous field.
// - First headerless field after reset is interlaced with default polarity.
// - Weave and motion discard a field repeating the previous polarity.
// - Bob synced to one polarity discards the other polarity.
// - Buffered bob synced to both polarities drops repeated polarities.
// - Unbuffered bob synced to both polarities keeps every interlaced field.
// - Progressive fields are discarded unless passthrough is built in.
// - Control and user packets pass once, stored or forwarded, never repeated.
// - A fresh control packet precedes every processed image.
// - Output nibble is 0010 or 0011 when deinterlaced, 0000 when passed through.
// - The field holding the top line is the top field.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dfbc_top #(
  parameter dfbc_pkg::dfbc_method_type METHOD    = dfbc_pkg::DFBC_BOB_INT,
  parameter dfbc_pkg::dfbc_buf_type    BUFFERING = dfbc_pkg::DFBC_BUF_TRIPLE,
  parameter bit                        SYNC_BOTH   = 1'b1,
  parameter bit                        CUR_BOTTOM  = 1'b1,
  parameter bit                        INIT_BOTTOM = 1'b0,
  parameter bit                        PASSTHRU    = 1'b0,
  parameter bit                        BURST_ALIGN = 1'b1,
  parameter bit                        LOCKED_RATE = 1'b0,
  parameter bit                        MA_OVERRIDE = 1'b0,
  parameter int                        RD_BURST    = 32,
  parameter int                        WR_BURST    = 32,
  parameter int                        BEAT_BYTES  = 4,
  parameter int                        FRAME_BYTES = 8294400
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        IN_CTRL_PKT,
  input  wire logic [3:0]  IN_CTRL_NIBBLE,
  input  wire logic [15:0] IN_CTRL_HEIGHT,
  input  wire logic        IN_USER_PKT,
  input  wire logic        IN_FIELD_START,
  input  wire logic        IN_FIELD_END,
  input  wire logic        OUT_FRAME_START,
  input  wire logic        OUT_FRAME_END,
  output logic             FIELD_KEEP,
  output logic             FIELD_DISCARD,
  output logic             FIELD_BOTTOM,
  output logic             FIELD_PROG,
  output logic             IN_WAIT,
  output logic             FRAME_REPEAT,
  output logic      [31:0] WR_BASE,
  output logic      [31:0] RD_BASE,
  output logic      [31:0] RD_PREV_BASE,
  output logic             PKT_FORWARD,
  output logic             PKT_STORE,
  output logic             CTRL_EMIT,
  output logic      [15:0] CTRL_HEIGHT,
  output logic      [3:0]  CTRL_NIBBLE
);
  // Weave and motion cannot run unbuffered, so such a build falls back to double.
  localparam bit NEED_BUF = (METHOD == dfbc_pkg::DFBC_WEAVE) ||
                            (METHOD == dfbc_pkg::DFBC_MOTION);
  localparam dfbc_pkg::dfbc_buf_type BUF_EFF =
    (NEED_BUF && BUFFERING == dfbc_pkg::DFBC_BUF_NONE) ? dfbc_pkg::DFBC_BUF_DOUBLE
                                                       : BUFFERING;
  localparam bit BUFFERED = (BUF_EFF != dfbc_pkg::DFBC_BUF_NONE);
  localparam bit TRIPLE   = (BUF_EFF == dfbc_pkg::DFBC_BUF_TRIPLE);
  localparam bit MOTION   = (METHOD == dfbc_pkg::DFBC_MOTION);
  localparam bit PAIRS    = NEED_BUF || (SYNC_BOTH && BUFFERED);
  // Locked rate is a double-buffer feature and excludes the motion override.
  localparam bit LOCK_OK  = LOCKED_RATE && !TRIPLE && BUFFERED && !MA_OVERRIDE;
  // Stride is rounded to the larger burst so each burst starts on a boundary.
  localparam int BURST    = (RD_BURST > WR_BURST) ? RD_BURST : WR_BURST;
  localparam int ALIGN    = BURST_ALIGN ? BURST * BEAT_BYTES : BEAT_BYTES;
  localparam int STRIDE   = ((FRAME_BYTES + ALIGN - 1) / ALIGN) * ALIGN;

  function automatic logic [31:0] area_base(input logic [1:0] id);
    area_base = dfbc_pkg::MEM_BASE + 32'(id) * 32'(STRIDE);
  endfunction

  logic        ack_q, lock_q, hdr_q, seen_q, last_prog_q, last_bot_q, act_q;
  logic [15:0] in_rate_q, out_rate_q, drops_q, reps_q, hdr_h_q;
  logic [3:0]  hdr_nib_q;
  logic [16:0] in_ph_q, out_ph_q, in_sum, out_sum;
  logic [31:0] dat_q;
  logic [15:0] meta_h_q [4];
  logic        meta_p_q [4];
  logic        meta_b_q [4];
  logic        cur_prog, cur_bot, cur_keep, lock_en, in_keep, out_take;
  logic        in_done, out_done, mgr_clean, mgr_wait, mgr_drop, mgr_rep;
  logic [1:0]  wr_id, rd_id, pv_id, src_id;
  logic        wb_req;

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;

  // Answer comes one cycle after the request and falls right after.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          dfbc_pkg::ADR_CTRL:     dat_q <= {31'h0000_0000, lock_q};
          dfbc_pkg::ADR_IN_RATE:  dat_q <= {16'h0000, in_rate_q};
          dfbc_pkg::ADR_OUT_RATE: dat_q <= {16'h0000, out_rate_q};
          dfbc_pkg::ADR_STATUS:   dat_q <= {23'h00_0000, seen_q, mgr_wait, mgr_clean,
                                            pv_id, rd_id, wr_id};
          dfbc_pkg::ADR_DROPS:    dat_q <= {16'h0000, drops_q};
          dfbc_pkg::ADR_REPEATS:  dat_q <= {16'h0000, reps_q};
          default:                dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Rates may change while frames run; the phases simply continue.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      lock_q     <= 1'b0;
      in_rate_q  <= dfbc_pkg::RATE_RST;
      out_rate_q <= dfbc_pkg::RATE_RST;
    end else if (wb_req && WB_WE_I) begin
      if (WB_ADR_I == dfbc_pkg::ADR_CTRL && WB_SEL_I[0]) begin
        lock_q <= WB_DAT_I[dfbc_pkg::CTRL_LOCK];
      end
      if (WB_ADR_I == dfbc_pkg::ADR_IN_RATE) begin
        if (WB_SEL_I[0]) in_rate_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) in_rate_q[15:8] <= WB_DAT_I[15:8];
      end
      if (WB_ADR_I == dfbc_pkg::ADR_OUT_RATE) begin
        if (WB_SEL_I[0]) out_rate_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) out_rate_q[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // Field type: header when present, else inferred from the previous field.
  always_comb begin
    cur_prog = 1'b0;
    cur_bot  = INIT_BOTTOM;
    if (hdr_q) begin
      cur_prog = !hdr_nib_q[dfbc_pkg::NIB_IL];
      cur_bot  = hdr_nib_q[dfbc_pkg::NIB_POL];
    end else if (seen_q) begin
      cur_prog = last_prog_q;
      cur_bot  = !last_bot_q;
    end
  end

  always_comb begin
    if (cur_prog) begin
      cur_keep = PASSTHRU;
    end else if (PAIRS) begin
      cur_keep = !(seen_q && !last_prog_q && cur_bot == last_bot_q);
    end else if (!SYNC_BOTH) begin
      cur_keep = (cur_bot == CUR_BOTTOM);
    end else begin
      cur_keep = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hdr_q       <= 1'b0;
      hdr_nib_q   <= dfbc_pkg::NIB_PROG;
      hdr_h_q     <= 16'h0000;
      seen_q      <= 1'b0;
      last_prog_q <= 1'b0;
      last_bot_q  <= 1'b0;
      act_q       <= 1'b0;
    end else begin
      if (IN_CTRL_PKT) begin
        hdr_q     <= 1'b1;
        hdr_nib_q <= IN_CTRL_NIBBLE;
        hdr_h_q   <= IN_CTRL_HEIGHT;
      end else if (IN_FIELD_START) begin
        hdr_q <= 1'b0;
      end
      if (IN_FIELD_START) begin
        seen_q      <= 1'b1;
        last_prog_q <= cur_prog;
        last_bot_q  <= cur_bot;
        act_q       <= cur_keep;
      end else if (IN_FIELD_END) begin
        act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FIELD_KEEP    <= 1'b0;
      FIELD_DISCARD <= 1'b0;
      FIELD_BOTTOM  <= 1'b0;
      FIELD_PROG    <= 1'b0;
    end else begin
      FIELD_KEEP    <= IN_FIELD_START && cur_keep;
      FIELD_DISCARD <= IN_FIELD_START && !cur_keep;
      if (IN_FIELD_START) begin
        FIELD_BOTTOM <= cur_bot;
        FIELD_PROG   <= cur_prog;
      end
    end
  end

  // Per-area description of the stored image, used to rebuild its header.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_meta
      always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
          meta_h_q[i] <= 16'h0000;
          meta_p_q[i] <= 1'b0;
          meta_b_q[i] <= 1'b0;
        end else if (IN_FIELD_START && cur_keep && wr_id == 2'(i)) begin
          meta_h_q[i] <= hdr_h_q;
          meta_p_q[i] <= cur_prog;
          meta_b_q[i] <= cur_bot;
        end
      end
    end
  endgenerate

  // Bresenham phases give a fixed drop and repeat pattern for given rates.
  assign lock_en  = LOCK_OK && lock_q;
  assign in_sum   = in_ph_q + {1'b0, out_rate_q};
  assign out_sum  = out_ph_q + {1'b0, in_rate_q};
  assign in_keep  = !lock_en || (in_sum >= {1'b0, in_rate_q});
  assign out_take = !lock_en || (out_sum >= {1'b0, out_rate_q});
  assign in_done  = BUFFERED && IN_FIELD_END && act_q;
  assign out_done = BUFFERED && OUT_FRAME_END;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      in_ph_q  <= 17'h0_0000;
      out_ph_q <= 17'h0_0000;
    end else begin
      if (!lock_en) begin
        in_ph_q  <= 17'h0_0000;
        out_ph_q <= 17'h0_0000;
      end else begin
        if (in_done) begin
          in_ph_q <= in_keep ? in_sum - {1'b0, in_rate_q} : in_sum;
        end
        if (out_done) begin
          out_ph_q <= out_take ? out_sum - {1'b0, out_rate_q} : out_sum;
        end
      end
    end
  end

  dfbc_bufmgr #(
    .TRIPLE (TRIPLE),
    .MOTION (MOTION)
  ) u_mgr (
    .clk         (MCLK),
    .rst         (RST),
    .in_done     (in_done),
    .in_keep     (in_keep),
    .out_done    (out_done),
    .out_take    (out_take),
    .wr_id       (wr_id),
    .rd_id       (rd_id),
    .pv_id       (pv_id),
    .spare_clean (mgr_clean),
    .in_wait     (mgr_wait),
    .dropped     (mgr_drop),
    .repeated    (mgr_rep)
  );

  // Addresses move only when ownership moves, once per frame.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      WR_BASE      <= dfbc_pkg::MEM_BASE;
      RD_BASE      <= dfbc_pkg::MEM_BASE;
      RD_PREV_BASE <= dfbc_pkg::MEM_BASE;
      IN_WAIT      <= 1'b0;
      FRAME_REPEAT <= 1'b0;
      drops_q      <= 16'h0000;
      reps_q       <= 16'h0000;
    end else begin
      WR_BASE      <= area_base(wr_id);
      RD_BASE      <= area_base(rd_id);
      RD_PREV_BASE <= area_base(pv_id);
      IN_WAIT      <= mgr_wait;
      FRAME_REPEAT <= mgr_rep;
      if (mgr_drop || (IN_FIELD_START && !cur_keep)) drops_q <= drops_q + 16'h0001;
      if (mgr_rep) reps_q <= reps_q + 16'h0001;
    end
  end

  // Non-image packets go out once; stored packets travel with their frame.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PKT_FORWARD <= 1'b0;
      PKT_STORE   <= 1'b0;
    end else begin
      PKT_FORWARD <= !BUFFERED && (IN_CTRL_PKT || IN_USER_PKT);
      PKT_STORE   <= BUFFERED && (IN_CTRL_PKT || IN_USER_PKT);
    end
  end

  // Unbuffered output follows the field being written; buffered reads its area.
  assign src_id = BUFFERED ? rd_id : wr_id;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CTRL_EMIT   <= 1'b0;
      CTRL_HEIGHT <= 16'h0000;
      CTRL_NIBBLE <= dfbc_pkg::NIB_PROG;
    end else begin
      CTRL_EMIT <= OUT_FRAME_START;
      if (OUT_FRAME_START) begin
        if (meta_p_q[src_id]) begin
          CTRL_HEIGHT <= meta_h_q[src_id];
          CTRL_NIBBLE <= dfbc_pkg::NIB_PROG;
        end else begin
          CTRL_HEIGHT <= {meta_h_q[src_id][14:0], 1'b0};
          CTRL_NIBBLE <= meta_b_q[src_id] ? dfbc_pkg::NIB_BOT : dfbc_pkg::NIB_TOP;
        end
      end
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_emit;
    CTRL_EMIT ##1 !CTRL_EMIT;
  endsequence

  a_header_first: assert property (OUT_FRAME_START && !$past(OUT_FRAME_START) |=> s_emit)
    else $error("no header before image");
  a_prog_drop: assert property (IN_FIELD_START && cur_prog && !PASSTHRU |=>
    FIELD_DISCARD && !FIELD_KEEP) else $error("progressive field kept");
  a_pol_repeat: assert property (IN_FIELD_START && PAIRS && !cur_prog && seen_q &&
    !last_prog_q && cur_bot == last_bot_q |=> FIELD_DISCARD)
    else $error("repeated polarity kept");
  a_first_field: assert property (IN_FIELD_START && !seen_q && !hdr_q |=>
    !FIELD_PROG && FIELD_BOTTOM == INIT_BOTTOM) else $error("bad first field type");
  a_nib_code: assert property (CTRL_EMIT |-> (CTRL_NIBBLE == dfbc_pkg::NIB_PROG) ==
    $past(meta_p_q[src_id])) else $error("interlace nibble wrong");
  a_pkt_once: assert property (IN_USER_PKT |=> (PKT_FORWARD ^ PKT_STORE))
    else $error("packet not passed exactly once");
endmodule
`default_nettype wire

/* shared/dfbc_pkg.sv */
`default_nettype none
package dfbc_pkg;
  // Register byte offsets.
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_IN_RATE  = 8'h04;
  localparam logic [7:0]  ADR_OUT_RATE = 8'h08;
  localparam logic [7:0]  ADR_STATUS   = 8'h0C;
  localparam logic [7:0]  ADR_DROPS    = 8'h10;
  localparam logic [7:0]  ADR_REPEATS  = 8'h14;
  localparam int          CTRL_LOCK    = 0;
  localparam logic [15:0] RATE_RST     = 16'h0001;
  localparam logic [31:0] MEM_BASE     = 32'h0000_0000;
  // Interlace nibble of a control packet.
  localparam int          NIB_IL       = 3;
  localparam int          NIB_POL      = 2;
  localparam logic [3:0]  NIB_PROG     = 4'h0;
  localparam logic [3:0]  NIB_TOP      = 4'h2;
  localparam logic [3:0]  NIB_BOT      = 4'h3;
  // Reset ownership of the frame areas.
  localparam logic [1:0]  WR_ID_RST    = 2'h0;
  localparam logic [1:0]  RD_ID_RST    = 2'h1;
  localparam logic [1:0]  PV_ID_RST    = 2'h2;
  localparam logic [1:0]  SP_ID_RST    = 2'h2;
  localparam logic [1:0]  SP_ID_RST_MA = 2'h3;
  typedef enum logic [1:0] {
    DFBC_BOB_DUP = 2'b00,
    DFBC_BOB_INT = 2'b01,
    DFBC_WEAVE   = 2'b10,
    DFBC_MOTION  = 2'b11
  } dfbc_method_type;
  typedef enum logic [1:0] {
    DFBC_BUF_NONE   = 2'b00,
    DFBC_BUF_DOUBLE = 2'b01,
    DFBC_BUF_TRIPLE = 2'b10
  } dfbc_buf_type;
endpackage
`default_nettype wire

/* testbench/deinterlacer_frame_buffer_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module deinterlacer_frame_buffer_control_bench;
  logic        mclk, rst, req, we, ack, ctrl_pkt;
  logic        keep, disc, bot, prog, rep, fwd, store, emit, iw, iw2;
  logic [7:0]  adr;
  logic [3:0]  sel, nib, c_nib;
  logic [4:0]  ev;
  logic [15:0] hgt, c_hgt;
  logic [31:0] wdat, rdat, junk, wr_base, rd_base, wr_base2, rd_base2, pv_base2;
  int          err_total, n_tests, cycles;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // A small frame keeps the area stride at 1024 bytes, a multiple of the 128-byte burst.
  dfbc_top #(.FRAME_BYTES(32'h0000_03E8)) dut (
    .MCLK(mclk), .RST(rst), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IN_CTRL_PKT(ctrl_pkt), .IN_CTRL_NIBBLE(nib), .IN_CTRL_HEIGHT(hgt),
    .IN_USER_PKT(ev[4]), .IN_FIELD_START(ev[3]), .IN_FIELD_END(ev[2]),
    .OUT_FRAME_START(ev[1]), .OUT_FRAME_END(ev[0]), .FIELD_KEEP(keep),
    .FIELD_DISCARD(disc), .FIELD_BOTTOM(bot), .FIELD_PROG(prog), .IN_WAIT(iw),
    .FRAME_REPEAT(rep), .WR_BASE(wr_base), .RD_BASE(rd_base), .RD_PREV_BASE(),
    .PKT_FORWARD(fwd), .PKT_STORE(store), .CTRL_EMIT(emit), .CTRL_HEIGHT(c_hgt),
    .CTRL_NIBBLE(c_nib));
  dfbc_far_model far (.clk(mclk), .ctrl_pkt(ctrl_pkt), .nib(nib), .hgt(hgt), .ev(ev));
  // A second build on the same stimulus covers motion double buffering and locked rate.
  dfbc_top #(.METHOD(dfbc_pkg::DFBC_MOTION), .BUFFERING(dfbc_pkg::DFBC_BUF_DOUBLE),
             .LOCKED_RATE(1'b1), .FRAME_BYTES(32'h0000_03E8)) dut2 (
    .MCLK(mclk), .RST(rst), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(), .WB_ACK_O(),
    .IN_CTRL_PKT(ctrl_pkt), .IN_CTRL_NIBBLE(nib), .IN_CTRL_HEIGHT(hgt),
    .IN_USER_PKT(ev[4]), .IN_FIELD_START(ev[3]), .IN_FIELD_END(ev[2]),
    .OUT_FRAME_START(ev[1]), .OUT_FRAME_END(ev[0]), .FIELD_KEEP(), .FIELD_DISCARD(),
    .FIELD_BOTTOM(), .FIELD_PROG(), .IN_WAIT(iw2), .FRAME_REPEAT(), .WR_BASE(wr_base2),
    .RD_BASE(rd_base2), .RD_PREV_BASE(pv_base2), .PKT_FORWARD(), .PKT_STORE(),
    .CTRL_EMIT(), .CTRL_HEIGHT(), .CTRL_NIBBLE());
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge mclk);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    req <= 1'b0;
    if (n >= 40) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0000_0000, q);
    chk(nm, e, q & m);
  endtask
  // Expected e holds keep, bottom and progressive; discard must be the inverse of keep.
  task automatic fld(input logic h, input logic [3:0] n, input logic [2:0] e);
    if (h) far.hdr(n, 16'h00F0);
    far.fire(5'h08);
    #1;
    chk("field verdict", {28'h0, e[2], ~e[2], e[1:0]}, {28'h0, keep, disc, bot, prog});
  endtask
  task automatic rep_chk(input logic [31:0] e);
    logic [31:0] c = 32'h0000_0000;
    repeat (4) begin
      @(posedge mclk);
      #1;
      if (rep === 1'b1) c++;
    end
    chk("frame repeats", e, c);
  endtask
  task automatic t_regs();
    rdc(dfbc_pkg::ADR_STATUS, 32'h0000_000F, 32'h0000_0004, "status ids");
    rdc(dfbc_pkg::ADR_IN_RATE, 32'h0000_FFFF, 32'h0000_0001, "in rate");
    wb(1'b1, dfbc_pkg::ADR_IN_RATE, 4'h3, 32'h5A5A_1234, junk);
    wb(1'b1, dfbc_pkg::ADR_OUT_RATE, 4'h1, 32'h0000_ABCD, junk);
    wb(1'b1, 8'h20, 4'hF, 32'hFFFF_FFFF, junk);
    rdc(dfbc_pkg::ADR_IN_RATE, 32'h0000_FFFF, 32'h0000_1234, "in rate");
    rdc(dfbc_pkg::ADR_OUT_RATE, 32'h0000_FFFF, 32'h0000_00CD, "out rate");
    rdc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
  endtask
  task automatic t_swap();
    fld(1'b0, 4'h0, 3'b100);
    far.fire(5'h04);
    repeat (2) @(posedge mclk);
    #1;
    chk("write base", 32'h0000_0800, wr_base);
    chk("in wait", 32'h0000_0000, {31'h0, iw});
    fld(1'b0, 4'h0, 3'b110);
    far.fire(5'h04);
    repeat (2) @(posedge mclk);
    #1;
    chk("write base", 32'h0000_0800, wr_base);
    rdc(dfbc_pkg::ADR_DROPS, 32'hFFFF_FFFF, 32'h0000_0001, "drops");
  endtask
  task automatic t_out();
    far.fire(5'h01);
    rep_chk(32'h0000_0000);
    fld(1'b1, 4'h8, 3'b100);
    far.fire(5'h04);
    far.fire(5'h01);
    rep_chk(32'h0000_0000);
    chk("read base", 32'h0000_0800, rd_base);
    far.fire(5'h02);
    #1;
    chk("ctrl", {11'h0, 1'b1, 16'h01E0, 4'h2}, {11'h0, emit, c_hgt, c_nib});
    far.fire(5'h01);
    rep_chk(32'h0000_0001);
    rdc(dfbc_pkg::ADR_REPEATS, 32'hFFFF_FFFF, 32'h0000_0001, "repeats");
  endtask
  task automatic t_disc();
    fld(1'b1, 4'h8, 3'b000);
    fld(1'b1, 4'h0, 3'b001);
    fld(1'b0, 4'h0, 3'b011);
    rdc(dfbc_pkg::ADR_DROPS, 32'hFFFF_FFFF, 32'h0000_0004, "drops");
  endtask
  task automatic t_same();
    far.hdr(4'hC, 16'h00F0);
    #1;
    chk("stored", 32'h0000_0002, {30'h0, store, fwd});
    far.fire(5'h10);
    #1;
    chk("stored", 32'h0000_0002, {30'h0, store, fwd});
    fld(1'b0, 4'h0, 3'b110);
    far.fire(5'h05);
    rep_chk(32'h0000_0001);
    rdc(dfbc_pkg::ADR_STATUS, 32'h0000_0043, 32'h0000_0040, "status");
    rdc(dfbc_pkg::ADR_DROPS, 32'hFFFF_FFFF, 32'h0000_0004, "drops");
  endtask
  // Input rate 2 against output rate 1: every other input frame is dropped.
  task automatic t_lock();
    wb(1'b1, dfbc_pkg::ADR_CTRL, 4'h1, 32'h0000_0001, junk);
    wb(1'b1, dfbc_pkg::ADR_IN_RATE, 4'h3, 32'h0000_0002, junk);
    wb(1'b1, dfbc_pkg::ADR_OUT_RATE, 4'h3, 32'h0000_0001, junk);
    rdc(dfbc_pkg::ADR_CTRL, 32'h0000_0001, 32'h0000_0001, "lock");
    fld(1'b0, 4'h0, 3'b100);
    far.fire(5'h04);
    repeat (2) @(posedge mclk);
    #1;
    chk("locked drop", 32'h0000_0000, {iw2, wr_base2[30:0]});
    fld(1'b0, 4'h0, 3'b110);
    far.fire(5'h04);
    repeat (2) @(posedge mclk);
    #1;
    chk("in wait", 32'h0000_0001, {31'h0, iw2});
    far.fire(5'h01);
    repeat (2) @(posedge mclk);
    #1;
    chk("read base", 32'h0000_0000, rd_base2);
    chk("write base", 32'h0000_0800, wr_base2);
    chk("prev base", 32'h0000_0400, pv_base2);
    chk("in wait", 32'h0000_0000, {31'h0, iw2});
  endtask
  // The ceiling leaves ample margin over the roughly 140 cycles the sequence needs.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  initial begin
    {rst, req, we, adr, sel, wdat, junk} = {1'b1, 78'h0};
    {err_total, n_tests, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_swap();
    t_out();
    t_disc();
    t_same();
    t_lock();
    complete_run();
  end
endmodule
`default_nettype wire

/* testbench/dfbc_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dfbc_far_model (
  input  wire logic  clk,
  output logic       ctrl_pkt,
  output logic [3:0]  nib,
  output logic [15:0] hgt,
  output logic [4:0]  ev
);
  // Header lines show the inverse of their last value between packets,
  // so a design that samples them late sees garbage, not a stale copy.
  initial begin
    ctrl_pkt = 1'b0;
    nib      = 4'h0;
    hgt      = 16'h0000;
    ev       = 5'h00;
  end
  task automatic hdr(input logic [3:0] n, input logic [15:0] h);
    @(posedge clk);
    ctrl_pkt <= 1'b1;
    nib      <= n;
    hgt      <= h;
    @(posedge clk);
    ctrl_pkt <= 1'b0;
    nib      <= ~n;
    hgt      <= ~h;
  endtask
  // Bits of m are user packet, field start, field end, frame start and frame end.
  task automatic fire(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
  endtask
endmodule
`default_nettype wire
